//--- shared/nvm_table_pkg.sv
// Constants, types and helpers shared by the table access and unlock logic
package nvm_table_pkg;

	localparam int PTR_W          = 22;
	localparam int STEP_W         = 21;
	localparam int WORD_W         = 16;
	localparam int BYTE_W         = 8;
	localparam int WORD_ADDR_W    = 21;
	localparam int HOLD_BYTES_DEF = 256;
	localparam int REGION_LSB     = 16;
	localparam int SECTOR_LSB     = 8;

	localparam logic [7:0] KEY_WORD_FIRST    = 8'h55;
	localparam logic [7:0] KEY_WORD_SECOND   = 8'haa;
	localparam logic [7:0] KEY_SECTOR_WRITE_TRIGGER_FIRST   = 8'hdd;
	localparam logic [7:0] KEY_SECTOR_WRITE_TRIGGER_SECOND  = 8'h22;
	localparam logic [7:0] KEY_SECTOR_ERASE_TRIGGER_FIRST   = 8'hcc;
	localparam logic [7:0] KEY_SECTOR_ERASE_TRIGGER_SECOND  = 8'h33;
	localparam logic [7:0] KEY_SECTOR_READ_TRIGGER_FIRST   = 8'hbb;
	localparam logic [7:0] KEY_SECTOR_READ_TRIGGER_SECOND  = 8'h44;

	// Cycles from first key write to second key write; the trigger comes one cycle after that
	localparam logic [1:0] KEY_GAP_CYCLES  = 2'h2;

	localparam logic [5:0] DATA_FLASH_REGION = 6'h31;

	localparam int OPCTL_WORD_BIT  = 0;
	localparam int OPCTL_SECTOR_READ_TRIGGER_BIT = 1;
	localparam int OPCTL_SECTOR_WRITE_TRIGGER_BIT = 2;
	localparam int OPCTL_SECTOR_ERASE_TRIGGER_BIT = 3;
	localparam int OPCTL_W         = 4;

	localparam int ENCTL_ACCESS_BIT = 0;
	localparam int ENCTL_DONE_BIT   = 1;
	localparam int ENCTL_IE_BIT     = 2;
	localparam int ENCTL_W          = 3;

	localparam logic [7:0]        LATCH_RST = 8'h00;
	localparam logic [PTR_W-1:0]  PTR_RST   = 22'h000000;
	localparam logic [OPCTL_W-1:0] OPCTL_RST = 4'h0;
	localparam logic [ENCTL_W-1:0] ENCTL_RST = 3'h0;

	typedef enum logic [3:0] {
		SEL_NONE, SEL_LATCH, SEL_PTR_L, SEL_PTR_H, SEL_PTR_U,
		SEL_ADR_L, SEL_ADR_H, SEL_ADR_U, SEL_KEY, SEL_OPCTL, SEL_ENCTL
	} sfr_sel_type;

	typedef enum logic [1:0] {
		PTR_KEEP, PTR_POST_INC, PTR_POST_DEC, PTR_PRE_INC
	} ptr_mode_type;

	typedef enum logic [2:0] {
		OP_NONE, OP_WORD_WRITE, OP_SECTOR_READ, OP_SECTOR_WRITE,
		OP_SECTOR_ERASE
	} nvm_op_type;

	typedef struct packed {
		logic        valid;
		sfr_sel_type sel;
		logic [7:0]  data;
	} sfr_write_type;

	typedef struct packed {
		logic         read;
		logic         write;
		ptr_mode_type mode;
	} table_req_type;

	typedef struct packed {
		logic             valid;
		nvm_op_type       op;
		logic [PTR_W-1:0] addr;
	} flash_cmd_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] idx;
		logic [7:0] data;
	} hold_fill_type;

	// Steps only bits 20:0; bit 21 is kept
	function automatic logic [PTR_W-1:0] ptr_step(
		input logic [PTR_W-1:0] ptr, input logic down);
		logic [STEP_W-1:0] low;
		low = down ? ptr[STEP_W-1:0] - 1'b1 : ptr[STEP_W-1:0] + 1'b1;
		return {ptr[PTR_W-1], low};
	endfunction

	function automatic nvm_op_type first_key_op(input logic [7:0] key);
		case (key)
			KEY_WORD_FIRST:  return OP_WORD_WRITE;
			KEY_SECTOR_WRITE_TRIGGER_FIRST: return OP_SECTOR_WRITE;
			KEY_SECTOR_ERASE_TRIGGER_FIRST: return OP_SECTOR_ERASE;
			KEY_SECTOR_READ_TRIGGER_FIRST: return OP_SECTOR_READ;
			default:         return OP_NONE;
		endcase
	endfunction

	function automatic logic [7:0] second_key(input nvm_op_type op);
		case (op)
			OP_WORD_WRITE:   return KEY_WORD_SECOND;
			OP_SECTOR_WRITE: return KEY_SECTOR_WRITE_TRIGGER_SECOND;
			OP_SECTOR_ERASE: return KEY_SECTOR_ERASE_TRIGGER_SECOND;
			OP_SECTOR_READ:  return KEY_SECTOR_READ_TRIGGER_SECOND;
			default:         return 8'h00;
		endcase
	endfunction

	function automatic nvm_op_type trigger_op(input logic [7:0] data);
		if (data[OPCTL_WORD_BIT])
			return OP_WORD_WRITE;
		if (data[OPCTL_SECTOR_READ_TRIGGER_BIT])
			return OP_SECTOR_READ;
		if (data[OPCTL_SECTOR_WRITE_TRIGGER_BIT])
			return OP_SECTOR_WRITE;
		if (data[OPCTL_SECTOR_ERASE_TRIGGER_BIT])
			return OP_SECTOR_ERASE;
		return OP_NONE;
	endfunction

endpackage

//--- hdl/nvm_unlock_seq.sv
// Keyed unlock sequencer that arms one nonvolatile memory operation
`timescale 1ns/1ps
module nvm_unlock_seq
	import nvm_table_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       reset_n_in,
	input  wire logic       key_wr_in,
	input  wire logic [7:0] key_data_in,
	input  wire logic       trig_wr_in,
	input  wire nvm_op_type trig_op_in,
	input  wire logic       access_en_in,
	input  wire logic       idle_in,
	output nvm_op_type      fire_out
);

	typedef enum logic [1:0] {
		U_IDLE  = 2'b00,
		U_WAIT2 = 2'b01,
		U_ARMED = 2'b11
	} unlock_state_type;

	unlock_state_type state_reg;
	nvm_op_type       pend_reg;
	logic [1:0]       gap_reg;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg <= U_IDLE;
			pend_reg  <= OP_NONE;
			gap_reg   <= 2'h0;
		end else begin
			case (state_reg)
				U_IDLE: begin
					gap_reg <= 2'h1;
					if (key_wr_in && first_key_op(key_data_in) != OP_NONE) begin
						state_reg <= U_WAIT2;
						pend_reg  <= first_key_op(key_data_in);
					end
				end
				U_WAIT2: begin
					gap_reg <= gap_reg + 2'h1;
					// Early, late or wrong second key drops the sequence
					if (key_wr_in) begin
						if (gap_reg == KEY_GAP_CYCLES &&
						    key_data_in == second_key(pend_reg))
							state_reg <= U_ARMED;
						else
							state_reg <= U_IDLE;
					end else if (gap_reg == KEY_GAP_CYCLES) begin
						state_reg <= U_IDLE;
					end
				end
				U_ARMED: begin
					state_reg <= U_IDLE;
				end
				default: begin
					state_reg <= U_IDLE;
				end
			endcase
		end
	end

	// Trigger counts only on the cycle right after the second key
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			fire_out <= OP_NONE;
		end else if (state_reg == U_ARMED && trig_wr_in && idle_in &&
		             trig_op_in == pend_reg && !key_wr_in &&
		             (access_en_in || pend_reg == OP_SECTOR_READ)) begin
			fire_out <= pend_reg;
		end else begin
			fire_out <= OP_NONE;
		end
	end

endmodule

//--- hdl/nvm_table_access.sv
// Table read/write path, holding registers and flash operation control
`timescale 1ns/1ps
// Behaviour
// - An 8-bit table data latch takes read bytes and feeds written bytes.
// - Table read uses all 22 pointer bits to fetch one byte into latch.
// - Table write only fills one holding register; flash stays untouched.
// - Low pointer bits pick the holding register; upper bits ignored.
// - Sector write sends whole holding block to sector from upper address.
// - Table accesses are single bytes at any address, no alignment.
// - CPU stalls during table read; latch valid next instruction cycle.
// - Pointer bit zero picks high or low byte of the 16-bit word.
// - Erase, sector write/read and word writes need a full unlock first.
// - Keys per operation: 55/AA, DD/22, CC/33, BB/44.
// - Program flash and config operations stall CPU; data flash does not.
// - Unlock steps must land on exact cycles; disturbed timing aborts.
// - Holding block is 256 bytes; pointer low eight bits index it.
// - Pointer increment and decrement touch only bits 20 down to 0.
// - On finish the trigger clears, done flag sets, interrupt if enabled.
module nvm_table_access
	import nvm_table_pkg::*;
#(
	parameter int HOLD_BYTES = HOLD_BYTES_DEF,
	parameter int IDX_W      = $clog2(HOLD_BYTES)
)(
	input  wire logic              clk_in,
	input  wire logic              reset_n_in,
	input  wire sfr_write_type     sfr_wr_in,
	input  wire table_req_type     table_req_in,
	input  wire logic [WORD_W-1:0] flash_rd_data_in,
	input  wire logic              flash_rd_valid_in,
	input  wire logic              flash_done_in,
	input  wire logic [IDX_W-1:0]  hold_rd_idx_in,
	input  wire hold_fill_type     hold_fill_in,
	output logic                   cpu_stall_out,
	output logic [BYTE_W-1:0]      table_data_latch_out,
	output logic [PTR_W-1:0]       table_byte_pointer_out,
	output logic [PTR_W-1:0]       nvm_address_out,
	output logic [OPCTL_W-1:0]     nvm_operation_control_out,
	output logic [ENCTL_W-1:0]     nvm_enable_control_out,
	output logic                   nvm_done_irq_out,
	output logic                   flash_rd_req_out,
	output logic [WORD_ADDR_W-1:0] flash_rd_addr_out,
	output flash_cmd_type          flash_cmd_out,
	output logic [BYTE_W-1:0]      hold_rd_data_out
);

	// Refused at elaboration: the hold fill index is only eight bits wide
	if (HOLD_BYTES < 2 || HOLD_BYTES > 256 ||
	    (1 << IDX_W) != HOLD_BYTES) begin
		$error("HOLD_BYTES must be a power of two from 2 to 256");
	end

	typedef enum logic [1:0] {
		S_IDLE  = 2'b00,
		S_TABLE_READ_INSTR = 2'b01,
		S_FLASH = 2'b11
	} access_state_type;

	access_state_type  state_reg;
	logic [BYTE_W-1:0] hold_mem [HOLD_BYTES];
	logic              byte_sel_reg;
	nvm_op_type        fire_op;
	nvm_op_type        trig_op;
	logic [PTR_W-1:0]  eff_ptr;
	logic [PTR_W-1:0]  next_ptr;
	logic              key_wr;
	logic              trig_wr;
	logic              table_go;
	logic              op_stalls;
	logic [PTR_W-1:0]  sector_base;

	assign key_wr  = sfr_wr_in.valid && sfr_wr_in.sel == SEL_KEY;
	assign trig_wr = sfr_wr_in.valid && sfr_wr_in.sel == SEL_OPCTL;
	assign trig_op = trigger_op(sfr_wr_in.data);
	// Table ops are only served while nothing else owns the array
	assign table_go = state_reg == S_IDLE &&
	                  (table_req_in.read || table_req_in.write);

	// Effective and next pointer for the table instruction modes
	always_comb begin
		eff_ptr  = table_byte_pointer_out;
		next_ptr = table_byte_pointer_out;
		case (table_req_in.mode)
			PTR_PRE_INC: begin
				eff_ptr  = ptr_step(table_byte_pointer_out, 1'b0);
				next_ptr = eff_ptr;
			end
			PTR_POST_INC: begin
				next_ptr = ptr_step(table_byte_pointer_out, 1'b0);
			end
			PTR_POST_DEC: begin
				next_ptr = ptr_step(table_byte_pointer_out, 1'b1);
			end
			default: begin
				next_ptr = table_byte_pointer_out;
			end
		endcase
	end

	// Data flash region runs in the background, the rest freezes the CPU
	assign op_stalls = nvm_address_out[PTR_W-1:REGION_LSB] !=
	                   DATA_FLASH_REGION;
	assign sector_base = {nvm_address_out[PTR_W-1:SECTOR_LSB],
	                      {SECTOR_LSB{1'b0}}};

	nvm_unlock_seq unlock_inst (
		.clk_in      (clk_in),
		.reset_n_in  (reset_n_in),
		.key_wr_in   (key_wr),
		.key_data_in (sfr_wr_in.data),
		.trig_wr_in  (trig_wr),
		.trig_op_in  (trig_op),
		.access_en_in(nvm_enable_control_out[ENCTL_ACCESS_BIT]),
		.idle_in     (state_reg == S_IDLE),
		.fire_out    (fire_op)
	);

	// Owner of the array: idle, table read or flash operation
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg <= S_IDLE;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (fire_op != OP_NONE)
						state_reg <= S_FLASH;
					else if (table_req_in.read)
						state_reg <= S_TABLE_READ_INSTR;
				end
				S_TABLE_READ_INSTR: begin
					if (flash_rd_valid_in)
						state_reg <= S_IDLE;
				end
				S_FLASH: begin
					if (flash_done_in)
						state_reg <= S_IDLE;
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	// CPU stall; data flash work leaves the CPU running meanwhile
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cpu_stall_out <= 1'b0;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (fire_op != OP_NONE)
						cpu_stall_out <= op_stalls;
					else if (table_req_in.read)
						cpu_stall_out <= 1'b1;
				end
				S_TABLE_READ_INSTR: begin
					if (flash_rd_valid_in)
						cpu_stall_out <= 1'b0;
				end
				S_FLASH: begin
					if (flash_done_in)
						cpu_stall_out <= 1'b0;
				end
				default: begin
					cpu_stall_out <= 1'b0;
				end
			endcase
		end
	end

	// Array read: one-cycle request carrying the word address
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			flash_rd_req_out  <= 1'b0;
			flash_rd_addr_out <= '0;
			byte_sel_reg      <= 1'b0;
		end else begin
			flash_rd_req_out <= 1'b0;
			if (state_reg == S_IDLE && fire_op == OP_NONE &&
			    table_req_in.read) begin
				flash_rd_req_out  <= 1'b1;
				flash_rd_addr_out <= eff_ptr[PTR_W-1:1];
				byte_sel_reg      <= eff_ptr[0];
			end
		end
	end

	// Operation command to the array; valid is a one-cycle pulse
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			flash_cmd_out <= '0;
		end else begin
			flash_cmd_out.valid <= 1'b0;
			if (state_reg == S_IDLE && fire_op != OP_NONE) begin
				flash_cmd_out.valid <= 1'b1;
				flash_cmd_out.op    <= fire_op;
				// Word writes keep the full address
				flash_cmd_out.addr  <= fire_op == OP_WORD_WRITE ?
				                       nvm_address_out : sector_base;
			end
		end
	end

	// Table data latch
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			table_data_latch_out <= LATCH_RST;
		end else if (state_reg == S_TABLE_READ_INSTR && flash_rd_valid_in) begin
			table_data_latch_out <= byte_sel_reg ?
			                        flash_rd_data_in[WORD_W-1:BYTE_W] :
			                        flash_rd_data_in[BYTE_W-1:0];
		end else if (sfr_wr_in.valid && sfr_wr_in.sel == SEL_LATCH) begin
			table_data_latch_out <= sfr_wr_in.data;
		end
	end

	// Table pointer; an instruction's own step wins over a register write
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			table_byte_pointer_out <= PTR_RST;
		end else if (table_go) begin
			table_byte_pointer_out <= next_ptr;
		end else if (sfr_wr_in.valid) begin
			case (sfr_wr_in.sel)
				SEL_PTR_L: table_byte_pointer_out[7:0]   <= sfr_wr_in.data;
				SEL_PTR_H: table_byte_pointer_out[15:8]  <= sfr_wr_in.data;
				SEL_PTR_U: table_byte_pointer_out[21:16] <= sfr_wr_in.data[5:0];
				default:   table_byte_pointer_out <= table_byte_pointer_out;
			endcase
		end
	end

	// Address register for the operation controls
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			nvm_address_out <= PTR_RST;
		end else if (sfr_wr_in.valid) begin
			case (sfr_wr_in.sel)
				SEL_ADR_L: nvm_address_out[7:0]   <= sfr_wr_in.data;
				SEL_ADR_H: nvm_address_out[15:8]  <= sfr_wr_in.data;
				SEL_ADR_U: nvm_address_out[21:16] <= sfr_wr_in.data[5:0];
				default:   nvm_address_out <= nvm_address_out;
			endcase
		end
	end

	// Holding registers are not reset; their content is undefined
	always_ff @(posedge clk_in) begin
		if (table_go && table_req_in.write)
			hold_mem[eff_ptr[IDX_W-1:0]] <= table_data_latch_out;
		if (state_reg == S_FLASH && flash_cmd_out.op == OP_SECTOR_READ &&
		    hold_fill_in.valid)
			hold_mem[hold_fill_in.idx[IDX_W-1:0]] <= hold_fill_in.data;
		hold_rd_data_out <= hold_mem[hold_rd_idx_in];
	end

	// Trigger bits: only a fired operation sets one, completion clears it
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			nvm_operation_control_out <= OPCTL_RST;
		end else if (state_reg == S_IDLE && fire_op != OP_NONE) begin
			case (fire_op)
				OP_WORD_WRITE:
					nvm_operation_control_out[OPCTL_WORD_BIT] <= 1'b1;
				OP_SECTOR_READ:
					nvm_operation_control_out[OPCTL_SECTOR_READ_TRIGGER_BIT] <= 1'b1;
				OP_SECTOR_WRITE:
					nvm_operation_control_out[OPCTL_SECTOR_WRITE_TRIGGER_BIT] <= 1'b1;
				default:
					nvm_operation_control_out[OPCTL_SECTOR_ERASE_TRIGGER_BIT] <= 1'b1;
			endcase
		end else if (state_reg == S_FLASH && flash_done_in) begin
			nvm_operation_control_out <= OPCTL_RST;
		end else begin
			nvm_operation_control_out <= nvm_operation_control_out;
		end
	end

	// Enable, done flag and its interrupt enable; completion beats a clear
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			nvm_enable_control_out <= ENCTL_RST;
		end else begin
			if (sfr_wr_in.valid && sfr_wr_in.sel == SEL_ENCTL)
				nvm_enable_control_out <= sfr_wr_in.data[ENCTL_W-1:0];
			if (state_reg == S_FLASH && flash_done_in)
				nvm_enable_control_out[ENCTL_DONE_BIT] <= 1'b1;
		end
	end

	// Interrupt follows flag and enable one cycle later
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			nvm_done_irq_out <= 1'b0;
		else
			nvm_done_irq_out <= nvm_enable_control_out[ENCTL_DONE_BIT] &&
			                    nvm_enable_control_out[ENCTL_IE_BIT];
	end

endmodule

//--- bench/flash_array_model.sv
// Flash array stand-in: answers table reads and runs sector commands
`timescale 1ns/1ps
module flash_array_model
	import nvm_table_pkg::*;
(
	input  wire logic          clk_in,
	input  wire logic          reset_n_in,
	input  wire logic          rd_req_in,
	input  wire logic [20:0]   rd_addr_in,
	input  wire flash_cmd_type cmd_in,
	input  wire logic [7:0]    hold_data_in,
	input  wire logic [3:0]    lat_in,
	output logic [15:0]        rd_data_out,
	output logic               rd_valid_out,
	output logic               done_out,
	output logic [7:0]         hold_idx_out,
	output hold_fill_type      fill_out
);
	logic [7:0]  got [256];
	logic [20:0] addr_reg;
	logic [3:0]  wait_reg;
	logic        busy_reg;
	nvm_op_type  op_reg;
	logic [8:0]  cnt_reg;
	logic [15:0] noise_reg;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			addr_reg <= 21'h0;
			wait_reg <= 4'h0;
			busy_reg <= 1'b0;
			op_reg <= OP_NONE;
			cnt_reg <= 9'h0;
			noise_reg <= 16'h0;
			rd_valid_out <= 1'b0;
			done_out <= 1'b0;
		end else begin
			noise_reg <= noise_reg + 16'h3b1d;
			rd_valid_out <= busy_reg && wait_reg == 4'h0;
			done_out <= op_reg != OP_NONE && cnt_reg == 9'h101;
			if (rd_req_in) begin
				busy_reg <= 1'b1;
				wait_reg <= lat_in;
				addr_reg <= rd_addr_in;
			end else if (busy_reg) begin
				busy_reg <= wait_reg != 4'h0;
				wait_reg <= wait_reg - 4'h1;
			end
			if (cmd_in.valid) begin
				op_reg <= cmd_in.op;
				cnt_reg <= 9'h0;
			end else if (op_reg != OP_NONE) begin
				cnt_reg <= cnt_reg + 9'h1;
				if (cnt_reg == 9'h101)
					op_reg <= OP_NONE;
				if (op_reg == OP_SECTOR_WRITE && cnt_reg != 9'h0)
					got[cnt_reg[7:0] - 8'h01] <= hold_data_in;
			end
		end
	end
	// Idle data bus keeps moving so a stale word is never mistaken for data
	assign rd_data_out = rd_valid_out ? addr_reg[15:0] ^ 16'ha5c3 : noise_reg;
	assign hold_idx_out = cnt_reg[7:0];
	assign fill_out = {op_reg == OP_SECTOR_READ && !cnt_reg[8],
		cnt_reg[7:0], ~cnt_reg[7:0]};
endmodule

//--- bench/nvm_table_access_sva.sv
// Port assertions for the table access and unlock block
`timescale 1ns/1ps
module nvm_table_access_sva
	import nvm_table_pkg::*;
(
	input wire logic          clk_in,
	input wire logic          reset_n_in,
	input wire sfr_write_type sfr_wr_in,
	input wire table_req_type table_req_in,
	input wire logic [15:0]   flash_rd_data_in,
	input wire logic          flash_rd_valid_in,
	input wire logic          flash_done_in,
	input wire logic          cpu_stall_out,
	input wire logic [7:0]    table_data_latch_out,
	input wire logic [21:0]   table_byte_pointer_out,
	input wire logic [21:0]   nvm_address_out,
	input wire logic [3:0]    nvm_operation_control_out,
	input wire logic [2:0]    nvm_enable_control_out,
	input wire logic          nvm_done_irq_out,
	input wire logic          flash_rd_req_out,
	input wire logic [20:0]   flash_rd_addr_out,
	input wire flash_cmd_type flash_cmd_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);
	logic idle;
	logic hi_reg;
	assign idle = !cpu_stall_out && nvm_operation_control_out == 4'h0;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			hi_reg <= 1'b0;
		else if (table_req_in.read && idle)
			hi_reg <= table_byte_pointer_out[0]
				^ (table_req_in.mode == PTR_PRE_INC);
	end
	a_read_stalls: assert property (table_req_in.read && idle
		|=> cpu_stall_out && flash_rd_req_out) else $error("no read stall");
	a_read_addr: assert property (table_req_in.read && idle
		&& table_req_in.mode != PTR_PRE_INC |=> flash_rd_addr_out
		== $past(table_byte_pointer_out[21:1])) else $error("read addr");
	a_latch_byte: assert property (flash_rd_valid_in && idle == 0
		&& nvm_operation_control_out == 4'h0 |=> !cpu_stall_out
		&& table_data_latch_out == (hi_reg ? $past(flash_rd_data_in[15:8])
		: $past(flash_rd_data_in[7:0]))) else $error("latch byte");
	a_ptr_keep21: assert property (table_req_in.write && idle
		|=> $stable(table_byte_pointer_out[21])) else $error("bit 21");
	a_post_inc: assert property ((table_req_in.read || table_req_in.write)
		&& idle && table_req_in.mode == PTR_POST_INC
		|=> table_byte_pointer_out[20:0]
		== $past(table_byte_pointer_out[20:0]) + 21'h1) else $error("inc");
	a_cmd_keys: assert property (flash_cmd_out.valid
		|-> $past(sfr_wr_in.valid && sfr_wr_in.sel == SEL_OPCTL, 2)
		&& $past(sfr_wr_in.valid && sfr_wr_in.sel == SEL_KEY, 3)
		&& $past(sfr_wr_in.valid && sfr_wr_in.sel == SEL_KEY, 5))
		else $error("cmd without keys");
	a_sector_addr: assert property (flash_cmd_out.valid
		&& flash_cmd_out.op != OP_WORD_WRITE |-> flash_cmd_out.addr
		== {nvm_address_out[21:8], 8'h00}) else $error("sector addr");
	a_enable_gate: assert property (flash_cmd_out.valid
		&& flash_cmd_out.op != OP_SECTOR_READ
		|-> nvm_enable_control_out[0]) else $error("enable off");
	a_stall_region: assert property (flash_cmd_out.valid
		|-> cpu_stall_out == (nvm_address_out[21:16] != DATA_FLASH_REGION))
		else $error("stall region");
	a_done_flag: assert property (flash_done_in
		&& nvm_operation_control_out != 4'h0 |=> nvm_operation_control_out
		== 4'h0 && nvm_enable_control_out[1] ##1 nvm_done_irq_out
		== nvm_enable_control_out[2]) else $error("done flag");
endmodule
bind nvm_table_access nvm_table_access_sva chk_u (.*);

//--- bench/tb_top.sv
// Self-checking bench for the table access and unlock block
`timescale 1ns/1ps
module tb_top
	import nvm_table_pkg::*;
;
	logic          clk_in, reset_n_in, rd_valid, done, stall, irq, rd_req;
	sfr_write_type sfr_wr_in;
	table_req_type table_req_in;
	hold_fill_type fill;
	flash_cmd_type cmd;
	logic [15:0]   rd_data;
	logic [7:0]    hold_idx, hold_data, latch;
	logic [21:0]   ptr, nvm_adr;
	logic [20:0]   rd_addr;
	logic [3:0]    opctl, lat;
	logic [2:0]    enctl;
	logic [7:0]    hold [256];
	logic [23:0]   bad [5] = '{24'hcc3408, 24'h55aa04, 24'hcc3308,
		24'hcc3308, 24'h000008};
	int            err_total, samples_checked, cmd_seen, n, c0;
	nvm_table_access dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.sfr_wr_in(sfr_wr_in), .table_req_in(table_req_in),
		.flash_rd_data_in(rd_data), .flash_rd_valid_in(rd_valid),
		.flash_done_in(done), .hold_rd_idx_in(hold_idx),
		.hold_fill_in(fill), .cpu_stall_out(stall),
		.table_data_latch_out(latch), .table_byte_pointer_out(ptr),
		.nvm_address_out(nvm_adr), .nvm_operation_control_out(opctl),
		.nvm_enable_control_out(enctl), .nvm_done_irq_out(irq),
		.flash_rd_req_out(rd_req), .flash_rd_addr_out(rd_addr),
		.flash_cmd_out(cmd), .hold_rd_data_out(hold_data));
	flash_array_model model_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.rd_req_in(rd_req), .rd_addr_in(rd_addr), .cmd_in(cmd),
		.hold_data_in(hold_data), .lat_in(lat), .rd_data_out(rd_data),
		.rd_valid_out(rd_valid), .done_out(done), .hold_idx_out(hold_idx),
		.fill_out(fill));
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	// Counted between edges so the pulse is seen once, settled
	always @(negedge clk_in)
		if (cmd.valid === 1'b1)
			cmd_seen++;
	task automatic chk(input logic [31:0] got, exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t %s", $time, msg);
		end
	endtask
	task automatic close_out();
		if (err_total == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tmo();
		if (n >= 400) begin
			err_total++;
			close_out();
		end
	endtask
	// Valid stays up between calls so back-to-back writes need no gap
	task automatic sfr(input sfr_sel_type sel, input logic [7:0] d);
		sfr_wr_in = '{1'b1, sel, d};
		@(negedge clk_in);
	endtask
	task automatic quiet(input int c);
		sfr_wr_in.valid = 1'b0;
		table_req_in = '0;
		repeat (c) @(negedge clk_in);
	endtask
	task automatic set22(input sfr_sel_type lo, input logic [21:0] v);
		sfr(lo, v[7:0]);
		sfr(sfr_sel_type'(lo + 1), v[15:8]);
		sfr(sfr_sel_type'(lo + 2), {2'b00, v[21:16]});
	endtask
	task automatic unlock(input logic [7:0] k1, k2, t, input int gap);
		sfr(SEL_KEY, k1);
		quiet(gap);
		sfr(SEL_KEY, k2);
		sfr(SEL_OPCTL, t);
		quiet(4);
	endtask
	task automatic finish_op();
		for (n = 0; opctl !== 4'h0 && n < 400; n++)
			@(negedge clk_in);
		tmo();
	endtask
	function automatic logic [21:0] stepped(input logic [21:0] p, input dn);
		return {p[21], dn ? p[20:0] - 21'h1 : p[20:0] + 21'h1};
	endfunction
	task automatic tbl(input logic rd, input ptr_mode_type m);
		logic [21:0] p, e;
		logic [15:0] w;
		p = ptr;
		e = (m == PTR_PRE_INC) ? stepped(p, 1'b0) : p;
		table_req_in = '{rd, !rd, m};
		@(negedge clk_in);
		quiet(1);
		for (n = 0; stall !== 1'b0 && n < 400; n++)
			@(negedge clk_in);
		tmo();
		w = e[16:1] ^ 16'ha5c3;
		if (rd)
			chk(latch, e[0] ? w[15:8] : w[7:0], "read byte");
		else
			hold[e[7:0]] = latch;
		chk(ptr, m == PTR_KEEP ? p : stepped(p, m == PTR_POST_DEC), "ptr");
	endtask
	initial begin
		void'($urandom(32'h93d89978));
		reset_n_in = 1'b0;
		sfr_wr_in = '0;
		table_req_in = '0;
		lat = 4'h0;
		repeat (6) @(negedge clk_in);
		reset_n_in = 1'b1;
		chk({latch, opctl, enctl}, {LATCH_RST, OPCTL_RST, ENCTL_RST}, "rst");
		for (int i = 0; i < 12; i++) begin
			set22(SEL_PTR_L, i == 0 ? 22'h3fffff : i == 1 ? 22'h1fffff
				: 22'($urandom));
			lat = 4'($urandom_range(5));
			quiet(1);
			tbl(1'b1, i < 2 ? PTR_POST_INC : ptr_mode_type'($urandom_range(3)));
		end
		set22(SEL_ADR_L, 22'h012345);
		sfr(SEL_ENCTL, 8'h01);
		unlock(8'hbb, 8'h44, 8'h02, 1);
		finish_op();
		for (int i = 0; i < 256; i++)
			hold[i] = 8'(~i);
		set22(SEL_PTR_L, 22'($urandom));
		c0 = cmd_seen;
		for (int i = 0; i < 8; i++) begin
			sfr(SEL_LATCH, 8'($urandom));
			quiet(1);
			tbl(1'b0, ptr_mode_type'($urandom_range(3)));
		end
		chk(cmd_seen - c0, 0, "table write reached flash");
		unlock(8'hdd, 8'h22, 8'h04, 1);
		finish_op();
		chk(enctl[1], 1'b1, "done flag");
		for (int i = 0; i < 256; i++)
			chk(model_u.got[i], hold[i], "sector data");
		for (int i = 0; i < 5; i++) begin
			c0 = cmd_seen;
			sfr(SEL_ENCTL, i == 3 ? 8'h00 : 8'h01);
			unlock(bad[i][23:16], bad[i][15:8], bad[i][7:0], i == 2 ? 2 : 1);
			chk((cmd_seen - c0) | opctl, 0, "refused op");
		end
		sfr(SEL_ENCTL, 8'h05);
		unlock(8'hcc, 8'h33, 8'h08, 1);
		chk({stall, opctl}, 5'h18, "erase stalls");
		finish_op();
		@(negedge clk_in);
		chk({enctl, irq}, 4'hf, "done irq");
		set22(SEL_ADR_L, 22'h310010);
		unlock(8'h55, 8'haa, 8'h01, 1);
		chk({stall, opctl}, 5'h01, "data flash runs free");
		finish_op();
		close_out();
	end
endmodule
